//--- rtl/ccg_pkg.sv
// shared constants for the crane game claw and configuration controller
package ccg_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SHOW_ZERO_MS = 500;
  localparam int SHOW_RATE_MS = 800;
  localparam int SHOW_BLANK_MS = 800;
  localparam int STEP_MS = 800;
  localparam int SHOW_ZERO_CYC = SHOW_ZERO_MS * (CLK_HZ / 1000);
  localparam int SHOW_RATE_CYC = SHOW_RATE_MS * (CLK_HZ / 1000);
  localparam int SHOW_BLANK_CYC = SHOW_BLANK_MS * (CLK_HZ / 1000);
  localparam int STEP_CYC = STEP_MS * (CLK_HZ / 1000);
  localparam int METER_ON_MS = 50;
  localparam int METER_OFF_MS = 50;
  localparam int METER_ON_CYC = METER_ON_MS * (CLK_HZ / 1000);
  localparam int METER_OFF_CYC = METER_OFF_MS * (CLK_HZ / 1000);
  localparam int BILL_PULSES = 4;
  localparam int CREDITS_PER_PLAY_X4 = 4;
  localparam int RATE_MULT = 10;
  // two digits on the display, one and one
  localparam logic [7:0] PRIZE_TEST_SHOW = 8'h11;
  // game option bank bits
  localparam int GO_CENTER = 0;
  localparam int GO_SHOW_PLAYS = 1;
  localparam int GO_ALARM = 2;
  localparam int GO_MULT = 3;
  localparam int GO_FREE = 7;
  // credit option bank bits
  localparam int CO_FOUR = 2;
  // test option bank bits
  localparam int TO_CLEAR_CREDITS = 0;
  localparam int TO_LOW_TEST = 2;
  localparam int TO_MID_TEST = 3;
  localparam int TO_HIGH_TEST = 4;
  localparam int TO_NO_ATTRACT = 5;
  localparam int TO_PRIZE_TEST = 6;
  localparam int TO_UNTIL_WIN = 7;
  localparam logic [7:0] WEIGHT [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h0A, 8'h14, 8'h1E, 8'h32};
  typedef enum logic [1:0] {CCG_OFF, CCG_HIGH, CCG_MIDDLE, CCG_LOW} ccg_level_t;
endpackage

//--- rtl/ccg_top.sv
// crane game claw strength sequencing, option decoding, meters and power-on display
// What this block does
// (RQ1) one of three claw strengths driven
// (RQ2) catch lowers claw; contact or recatch closes
// (RQ3) first close and rise uses high
// (RQ4) near top switches to middle
// (RQ5) top in normal game: low until home
// (RQ6) payout game: high, middle, high again
// (RQ7) single test bit holds claw closed
// (RQ8) no test bits: normal game play
// (RQ9) coin meter pulses once per coin
// (RQ10) bill meter pulses four per dollar
// (RQ11) prize meter pulses once per prize
// (RQ12) centering bit moves gantry to center
// (RQ13) display bit selects credits or plays
// (RQ14) alarm bit gates error alarm
// (RQ15) multiplier bit scales win rate by ten
// (RQ16) power-on display 00, rate, 00, countdown
// (RQ17) free play needs no credits
// (RQ18) four-credit bit costs four per play
// (RQ19) memory bit clears credits at reset
// (RQ20) attract bit set disables attract
// (RQ21) prize test shows 11, led follows beam
// (RQ22) play until win keeps same credit
// (RQ23) win rate is weighted switch sum
// (RQ24) switches sampled at reset release
`timescale 1ns/100ps
module ccg_top #(
  parameter int SHOW_ZERO_CYC = ccg_pkg::SHOW_ZERO_CYC,
  parameter int SHOW_RATE_CYC = ccg_pkg::SHOW_RATE_CYC,
  parameter int SHOW_BLANK_CYC = ccg_pkg::SHOW_BLANK_CYC,
  parameter int STEP_CYC = ccg_pkg::STEP_CYC,
  parameter int METER_ON_CYC = ccg_pkg::METER_ON_CYC,
  parameter int METER_OFF_CYC = ccg_pkg::METER_OFF_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] WIN_RATE_SWITCH_BANK_IN,
  input wire logic [7:0] GAME_OPTION_SWITCH_BANK_IN,
  input wire logic [7:0] CREDIT_OPTION_SWITCH_BANK_IN,
  input wire logic [7:0] TEST_OPTION_SWITCH_BANK_IN,
  input wire logic CATCH_IN,
  input wire logic BOTTOM_HIT_IN,
  input wire logic NEAR_TOP_IN,
  input wire logic TOP_LIMIT_IN,
  input wire logic HOME_IN,
  input wire logic PAYOUT_IN,
  input wire logic COIN_IN,
  input wire logic BILL_DOLLAR_IN,
  input wire logic PRIZE_BEAM_IN,
  input wire logic ERROR_IN,
  output logic [1:0] CLAW_LEVEL_OUT,
  output logic CLAW_DOWN_OUT,
  output logic CLAW_UP_OUT,
  output logic GAME_ACTIVE_OUT,
  output logic CENTER_GANTRY_OUT,
  output logic [7:0] DISPLAY_OUT,
  output logic ALARM_OUT,
  output logic ATTRACT_OUT,
  output logic PRIZE_SENSOR_LED_OUT,
  output logic COIN_METER_OUT,
  output logic BILL_METER_OUT,
  output logic PRIZE_METER_OUT,
  output logic [15:0] CREDITS_OUT,
  output logic [10:0] WIN_RATE_OUT
);
  typedef enum logic [2:0] {CCG_IDLE, CCG_DROP, CCG_RISE, CCG_NEAR, CCG_CARRY, CCG_TEST} ccg_claw_t;
  typedef enum logic [1:0] {CCG_PZERO, CCG_PRATE, CCG_PBLANK, CCG_PCOUNT} ccg_pwr_t;

  ////////////////////////////////////////////////////////////////////////////
  // switch capture while reset is held, frozen after release
  logic [7:0] rate_sw_r, game_sw_r, credit_sw_r, test_sw_r;
  // a switch moved during play has no effect until the next reset
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rate_sw_r <= WIN_RATE_SWITCH_BANK_IN; // [RQ24]
      game_sw_r <= GAME_OPTION_SWITCH_BANK_IN;
      credit_sw_r <= CREDIT_OPTION_SWITCH_BANK_IN;
      test_sw_r <= TEST_OPTION_SWITCH_BANK_IN;
    end
  end

  logic [2:0] test_bits;
  logic test_mode;
  ccg_pkg::ccg_level_t test_level;
  assign test_bits = {test_sw_r[ccg_pkg::TO_HIGH_TEST], test_sw_r[ccg_pkg::TO_MID_TEST],
                      test_sw_r[ccg_pkg::TO_LOW_TEST]};
  assign test_mode = (test_bits != 3'h0); // [RQ8]
  // two or more test bits leave the claw unpowered rather than guess a level
  always_comb begin
    unique case (test_bits) // [RQ7]
      3'h4: test_level = ccg_pkg::CCG_HIGH;
      3'h2: test_level = ccg_pkg::CCG_MIDDLE;
      3'h1: test_level = ccg_pkg::CCG_LOW;
      default: test_level = ccg_pkg::CCG_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // win rate: weighted sum per bit, times ten when the multiplier is on
  logic [7:0] part [8];
  logic [10:0] sum_nxt [9];
  assign sum_nxt[0] = 11'h000;
  generate
    for (genvar i = 0; i < 8; i++) begin : g_w
      assign part[i] = rate_sw_r[i] ? ccg_pkg::WEIGHT[i] : 8'h00; // [RQ23]
      assign sum_nxt[i + 1] = sum_nxt[i] + {3'h0, part[i]};
    end
  endgenerate
  logic [10:0] rate_nxt;
  assign rate_nxt = game_sw_r[ccg_pkg::GO_MULT] ? 11'(sum_nxt[8] * 11'(ccg_pkg::RATE_MULT)) : sum_nxt[8]; // [RQ15]
  // valid one edge after release, once the captured switches have settled
  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      WIN_RATE_OUT <= 11'h000;
    else
      WIN_RATE_OUT <= rate_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on display sequence
  ccg_pwr_t pwr_r;
  logic [23:0] pcnt_r;
  logic [7:0] count_digit_r;
  logic pwr_done;
  // the countdown stops at 00 and games stay locked out until then
  assign pwr_done = (pwr_r == CCG_PCOUNT) && (count_digit_r == 8'h00);
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pwr_r <= CCG_PZERO;
      pcnt_r <= 24'h000000;
      count_digit_r <= 8'h99;
    end else begin
      pcnt_r <= pcnt_r + 24'h000001;
      unique case (pwr_r) // [RQ16]
        CCG_PZERO: if (pcnt_r == 24'(SHOW_ZERO_CYC - 1)) begin
          pwr_r <= CCG_PRATE;
          pcnt_r <= 24'h000000;
        end
        CCG_PRATE: if (pcnt_r == 24'(SHOW_RATE_CYC - 1)) begin
          pwr_r <= CCG_PBLANK;
          pcnt_r <= 24'h000000;
        end
        CCG_PBLANK: if (pcnt_r == 24'(SHOW_BLANK_CYC - 1)) begin
          pwr_r <= CCG_PCOUNT;
          pcnt_r <= 24'h000000;
        end
        CCG_PCOUNT: begin
          if (count_digit_r == 8'h00)
            pcnt_r <= 24'h000000;
          else if (pcnt_r == 24'(STEP_CYC - 1)) begin
            pcnt_r <= 24'h000000;
            count_digit_r <= count_digit_r - 8'h11;
          end
        end
      endcase
    end
  end

  // hundreds of the win rate as two BCD digits
  logic [7:0] hundreds;
  logic [3:0] h_bin;
  // the rate tops out at 1210, so the hundreds never pass 12
  assign h_bin = 4'(rate_nxt / 11'h064);
  assign hundreds = (h_bin >= 4'hA) ? {4'h1, 4'(h_bin - 4'hA)} : {4'h0, h_bin};

  ////////////////////////////////////////////////////////////////////////////
  // credits: memory kept through reset unless the clear bit asks otherwise
  logic [15:0] cost;
  logic can_play, start_game, won_r, coin_d_r, bill_d_r, beam_d_r;
  logic coin_ev, bill_ev, prize_ev;
  logic catch_d_r, catch_ev;
  ccg_claw_t claw_r;
  // catch acts on its press, so a held button neither restarts a game nor closes the claw
  assign catch_ev = CATCH_IN & ~catch_d_r;
  assign coin_ev = COIN_IN & ~coin_d_r;
  assign bill_ev = BILL_DOLLAR_IN & ~bill_d_r;
  assign prize_ev = PRIZE_BEAM_IN & ~beam_d_r;
  assign cost = credit_sw_r[ccg_pkg::CO_FOUR] ? 16'(ccg_pkg::CREDITS_PER_PLAY_X4) : 16'h0001; // [RQ18]
  assign can_play = game_sw_r[ccg_pkg::GO_FREE] || (CREDITS_OUT >= cost); // [RQ17]
  // outside free play a start needs the full cost on hand, so the count never wraps below zero
  assign start_game = (claw_r == CCG_IDLE) && !test_mode && pwr_done && catch_ev && can_play;
  always_ff @(posedge CLK_IN) begin
    catch_d_r <= RST_IN ? 1'b0 : CATCH_IN;
    coin_d_r <= RST_IN ? 1'b0 : COIN_IN;
    bill_d_r <= RST_IN ? 1'b0 : BILL_DOLLAR_IN;
    beam_d_r <= RST_IN ? 1'b0 : PRIZE_BEAM_IN;
  end
  // credits stay unknown-free: cleared once at first reset by the bench or by the clear bit
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      if (TEST_OPTION_SWITCH_BANK_IN[ccg_pkg::TO_CLEAR_CREDITS])
        CREDITS_OUT <= 16'h0000; // [RQ19]
    end else begin
      // a game start that skips charging keeps the credit for play until win
      if (start_game && !game_sw_r[ccg_pkg::GO_FREE] && !(test_sw_r[ccg_pkg::TO_UNTIL_WIN] && !won_r))
        CREDITS_OUT <= CREDITS_OUT - cost + (coin_ev ? 16'h0001 : 16'h0000); // [RQ18] [RQ22]
      else if (coin_ev)
        CREDITS_OUT <= CREDITS_OUT + 16'h0001;
    end
  end
  // until-win: first game charges, later games ride free until a prize lands
  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      won_r <= 1'b1;
    else if (prize_ev)
      won_r <= 1'b1; // [RQ22]
    else if (start_game)
      won_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // claw sequencing
  // payout is latched at start so a change mid-game cannot split the sequence
  logic payout_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      claw_r <= CCG_IDLE;
      payout_r <= 1'b0;
      CLAW_LEVEL_OUT <= ccg_pkg::CCG_OFF;
      CLAW_DOWN_OUT <= 1'b0;
      CLAW_UP_OUT <= 1'b0;
    end else begin
      unique case (claw_r)
        CCG_IDLE: begin
          CLAW_LEVEL_OUT <= ccg_pkg::CCG_OFF;
          // the test bits are frozen, so test mode holds until the next reset
          if (test_mode) begin
            claw_r <= CCG_TEST;
          end else if (start_game) begin
            claw_r <= CCG_DROP; // [RQ2]
            payout_r <= PAYOUT_IN;
            CLAW_DOWN_OUT <= 1'b1;
          end
        end
        CCG_DROP: if (BOTTOM_HIT_IN || catch_ev) begin
          claw_r <= CCG_RISE; // [RQ2]
          CLAW_DOWN_OUT <= 1'b0;
          CLAW_UP_OUT <= 1'b1;
          CLAW_LEVEL_OUT <= ccg_pkg::CCG_HIGH; // [RQ3] [RQ1]
        end
        CCG_RISE: if (NEAR_TOP_IN) begin
          claw_r <= CCG_NEAR;
          CLAW_LEVEL_OUT <= ccg_pkg::CCG_MIDDLE; // [RQ4]
        end
        CCG_NEAR: if (TOP_LIMIT_IN) begin
          claw_r <= CCG_CARRY;
          CLAW_UP_OUT <= 1'b0;
          CLAW_LEVEL_OUT <= payout_r ? ccg_pkg::CCG_HIGH : ccg_pkg::CCG_LOW; // [RQ5] [RQ6]
        end
        CCG_CARRY: if (HOME_IN) begin
          claw_r <= CCG_IDLE;
          CLAW_LEVEL_OUT <= ccg_pkg::CCG_OFF; // [RQ5]
        end
        CCG_TEST: CLAW_LEVEL_OUT <= test_level; // [RQ7]
        default: claw_r <= CCG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // options, display and indicators
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      GAME_ACTIVE_OUT <= 1'b0;
      CENTER_GANTRY_OUT <= 1'b0;
      ALARM_OUT <= 1'b0;
      ATTRACT_OUT <= 1'b0;
      PRIZE_SENSOR_LED_OUT <= 1'b0;
      DISPLAY_OUT <= 8'h00;
    end else begin
      GAME_ACTIVE_OUT <= (claw_r != CCG_IDLE) && (claw_r != CCG_TEST);
      CENTER_GANTRY_OUT <= start_game && game_sw_r[ccg_pkg::GO_CENTER]; // [RQ12]
      ALARM_OUT <= ERROR_IN && game_sw_r[ccg_pkg::GO_ALARM]; // [RQ14]
      ATTRACT_OUT <= !test_sw_r[ccg_pkg::TO_NO_ATTRACT] && (claw_r == CCG_IDLE) && pwr_done; // [RQ20]
      PRIZE_SENSOR_LED_OUT <= test_sw_r[ccg_pkg::TO_PRIZE_TEST] && PRIZE_BEAM_IN; // [RQ21]
      if (test_sw_r[ccg_pkg::TO_PRIZE_TEST])
        DISPLAY_OUT <= 8'(ccg_pkg::PRIZE_TEST_SHOW); // [RQ21]
      else if (pwr_r == CCG_PRATE)
        DISPLAY_OUT <= hundreds; // [RQ16]
      else if (pwr_r != CCG_PCOUNT)
        DISPLAY_OUT <= 8'h00; // [RQ16]
      else if (!pwr_done)
        DISPLAY_OUT <= count_digit_r; // [RQ16]
      // credits and plays show as a binary low byte, not as two decimal digits
      else if (game_sw_r[ccg_pkg::GO_SHOW_PLAYS])
        DISPLAY_OUT <= 8'(CREDITS_OUT / cost); // [RQ13]
      else
        DISPLAY_OUT <= CREDITS_OUT[7:0]; // [RQ13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // meters: pending pulse counts, one timed pulse at a time per meter
  logic [2:0] ev_in;
  logic [2:0] meter_q;
  logic [3:0] add [3];
  assign ev_in = {prize_ev, bill_ev, coin_ev};
  assign add[0] = 4'h1; // [RQ9]
  assign add[1] = 4'(ccg_pkg::BILL_PULSES); // [RQ10]
  assign add[2] = 4'h1; // [RQ11]
  generate
    for (genvar m = 0; m < 3; m++) begin : g_m
      // an 8-bit pending count: a backlog past 255 pulses wraps, dropping 256 of them
      logic [7:0] pend_r;
      logic [19:0] mcnt_r;
      logic on_r;
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          pend_r <= 8'h00;
          mcnt_r <= 20'h00000;
          on_r <= 1'b0;
        end else begin
          if (mcnt_r != 20'h00000)
            mcnt_r <= mcnt_r - 20'h00001;
          else if (on_r) begin
            on_r <= 1'b0;
            mcnt_r <= 20'(METER_OFF_CYC - 1);
          end else if (pend_r != 8'h00) begin
            on_r <= 1'b1;
            mcnt_r <= 20'(METER_ON_CYC - 1);
          end
          // a new event in the cycle a pulse starts is still counted
          pend_r <= pend_r + (ev_in[m] ? {4'h0, add[m]} : 8'h00)
                    - ((mcnt_r == 20'h00000 && !on_r && pend_r != 8'h00) ? 8'h01 : 8'h00);
        end
      end
      assign meter_q[m] = on_r;
    end
  endgenerate
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      COIN_METER_OUT <= 1'b0;
      BILL_METER_OUT <= 1'b0;
      PRIZE_METER_OUT <= 1'b0;
    end else begin
      COIN_METER_OUT <= meter_q[0];
      BILL_METER_OUT <= meter_q[1];
      PRIZE_METER_OUT <= meter_q[2];
    end
  end
endmodule

//--- testbench/ccg_far_side.sv
// far-side model: claw travel sensors seen by the crane controller
`timescale 1ns/100ps
module ccg_far_side #(
  parameter int DROP = 6,
  parameter int RISE = 8,
  parameter int TRAVEL = 10
) (
  input wire logic clk_in,
  input wire logic claw_down_in,
  input wire logic claw_up_in,
  input wire logic [1:0] claw_level_in,
  output logic bottom_hit_out,
  output logic near_top_out,
  output logic top_limit_out,
  output logic home_out
);
  int dn_r = 0;
  int up_r = 0;
  int ret_r = 0;
  always_ff @(posedge clk_in) begin
    dn_r <= claw_down_in ? dn_r + 1 : 0;
    up_r <= claw_up_in ? up_r + 1 : 0;
    ret_r <= (claw_level_in != 2'h0 && !claw_down_in && !claw_up_in) ? ret_r + 1 : 0;
  end
  // contact stays a level while the claw rests on the pile
  assign bottom_hit_out = claw_down_in && dn_r >= DROP;
  assign near_top_out = claw_up_in && up_r >= RISE;
  // limits fall as soon as the motor stops, so a late reader sees no stale top
  assign top_limit_out = claw_up_in && up_r >= 2 * RISE;
  assign home_out = ret_r >= TRAVEL;
endmodule

//--- testbench/ccg_checker.sv
// port-level assertions for the crane game controller
`timescale 1ns/100ps
module ccg_checker #(
  parameter int METER_ON_CYC = 4
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] WIN_RATE_SWITCH_BANK_IN,
  input wire logic [7:0] GAME_OPTION_SWITCH_BANK_IN,
  input wire logic [7:0] TEST_OPTION_SWITCH_BANK_IN,
  input wire logic CATCH_IN,
  input wire logic BOTTOM_HIT_IN,
  input wire logic NEAR_TOP_IN,
  input wire logic TOP_LIMIT_IN,
  input wire logic PAYOUT_IN,
  input wire logic PRIZE_BEAM_IN,
  input wire logic ERROR_IN,
  input wire logic [1:0] CLAW_LEVEL_OUT,
  input wire logic CLAW_DOWN_OUT,
  input wire logic CLAW_UP_OUT,
  input wire logic CENTER_GANTRY_OUT,
  input wire logic ALARM_OUT,
  input wire logic PRIZE_SENSOR_LED_OUT,
  input wire logic COIN_METER_OUT,
  input wire logic [10:0] WIN_RATE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [15:0] on_r;
  logic [10:0] rate;
  always_ff @(posedge CLK_IN) begin
    on_r <= COIN_METER_OUT ? on_r + 16'h0001 : 16'h0000;
  end
  // switches are only ever changed while reset is high
  always_comb begin
    rate = 11'h000;
    for (int i = 0; i < 8; i++) begin
      if (WIN_RATE_SWITCH_BANK_IN[i]) rate = rate + 11'(ccg_pkg::WEIGHT[i]);
    end
    if (GAME_OPTION_SWITCH_BANK_IN[3]) rate = rate * 11'h00A;
  end
  ////////////////////////////////////////////////////////////
  sequence s_close;
    CLAW_DOWN_OUT && BOTTOM_HIT_IN;
  endsequence
  sequence s_lift;
    ##1 !CLAW_DOWN_OUT && CLAW_UP_OUT && CLAW_LEVEL_OUT == 2'h1;
  endsequence
  sequence s_recatch;
    CLAW_DOWN_OUT && CATCH_IN && !$past(CATCH_IN);
  endsequence
  grab_close_a: assert property (s_close |-> s_lift) else $error("claw not lifted at high");
  recatch_close_a: assert property (s_recatch |-> s_lift) else $error("claw not closed on recatch");
  drop_cause_a: assert property ($rose(CLAW_DOWN_OUT) |-> $past(CATCH_IN)) else $error("drop without catch");
  near_mid_a: assert property (CLAW_UP_OUT && NEAR_TOP_IN && !TOP_LIMIT_IN |=> CLAW_LEVEL_OUT == 2'h2)
    else $error("no middle near top");
  top_level_a: assert property ($fell(CLAW_UP_OUT) |-> CLAW_LEVEL_OUT == (PAYOUT_IN ? 2'h1 : 2'h3))
    else $error("wrong level at top");
  level_legal_a: assert property (CLAW_UP_OUT |-> CLAW_LEVEL_OUT != 2'h0) else $error("rising unpowered");
  alarm_gate_a: assert property (!$past(RST_IN) |-> ALARM_OUT == $past(ERROR_IN && GAME_OPTION_SWITCH_BANK_IN[2]))
    else $error("alarm gate wrong");
  led_beam_a: assert property (!$past(RST_IN) |->
    PRIZE_SENSOR_LED_OUT == $past(PRIZE_BEAM_IN && TEST_OPTION_SWITCH_BANK_IN[6])) else $error("led wrong");
  meter_width_a: assert property ($fell(COIN_METER_OUT) |-> on_r == METER_ON_CYC) else $error("meter width");
  center_opt_a: assert property (CENTER_GANTRY_OUT |-> GAME_OPTION_SWITCH_BANK_IN[0] ##1 !CENTER_GANTRY_OUT)
    else $error("centering wrong");
  rate_sum_a: assert property (!$past(RST_IN) |-> WIN_RATE_OUT == rate) else $error("win rate wrong");
endmodule
bind ccg_top ccg_checker #(.METER_ON_CYC(METER_ON_CYC)) ccg_checker_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .WIN_RATE_SWITCH_BANK_IN(WIN_RATE_SWITCH_BANK_IN), .GAME_OPTION_SWITCH_BANK_IN(GAME_OPTION_SWITCH_BANK_IN),
  .TEST_OPTION_SWITCH_BANK_IN(TEST_OPTION_SWITCH_BANK_IN), .CATCH_IN(CATCH_IN), .BOTTOM_HIT_IN(BOTTOM_HIT_IN),
  .NEAR_TOP_IN(NEAR_TOP_IN), .TOP_LIMIT_IN(TOP_LIMIT_IN), .PAYOUT_IN(PAYOUT_IN), .PRIZE_BEAM_IN(PRIZE_BEAM_IN),
  .ERROR_IN(ERROR_IN), .CLAW_LEVEL_OUT(CLAW_LEVEL_OUT), .CLAW_DOWN_OUT(CLAW_DOWN_OUT), .CLAW_UP_OUT(CLAW_UP_OUT),
  .CENTER_GANTRY_OUT(CENTER_GANTRY_OUT), .ALARM_OUT(ALARM_OUT), .PRIZE_SENSOR_LED_OUT(PRIZE_SENSOR_LED_OUT),
  .COIN_METER_OUT(COIN_METER_OUT), .WIN_RATE_OUT(WIN_RATE_OUT));

//--- testbench/tb.sv
// self-checking bench for the crane game controller
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] win = 8'h00, gopt = 8'h00, copt = 8'h00, topt = 8'h01;
  logic [3:0] ev = 4'h0;
  logic pay = 1'b0, err = 1'b0;
  logic hit, near, top, home, down, up, act, ctr, alarm, attr, led, cm, bm, pm;
  logic [1:0] lvl;
  logic [1:0] lv_old = 2'h0;
  logic [7:0] disp;
  logic [15:0] cred;
  logic [10:0] rate;
  logic cm_old = 1'b0, bm_old = 1'b0, pm_old = 1'b0;
  int bad_count = 0, cmp_count = 0, n_coin = 0, n_bill = 0, n_prize = 0, n_ctr = 0, n_hit = 0;
  localparam int PHASE_CYC = 10;
  localparam int METER_CYC = 4;
  logic [1:0] lvq[$];
  // short phases keep each power-on sequence near 120 cycles
  ccg_top #(.SHOW_ZERO_CYC(PHASE_CYC), .SHOW_RATE_CYC(PHASE_CYC), .SHOW_BLANK_CYC(PHASE_CYC), .STEP_CYC(PHASE_CYC),
    .METER_ON_CYC(METER_CYC), .METER_OFF_CYC(METER_CYC)) ccg_top_inst (.CLK_IN(clk), .RST_IN(rst),
    .WIN_RATE_SWITCH_BANK_IN(win),
    .GAME_OPTION_SWITCH_BANK_IN(gopt), .CREDIT_OPTION_SWITCH_BANK_IN(copt), .TEST_OPTION_SWITCH_BANK_IN(topt),
    .CATCH_IN(ev[3]), .BOTTOM_HIT_IN(hit), .NEAR_TOP_IN(near), .TOP_LIMIT_IN(top), .HOME_IN(home),
    .PAYOUT_IN(pay), .COIN_IN(ev[0]), .BILL_DOLLAR_IN(ev[1]), .PRIZE_BEAM_IN(ev[2]), .ERROR_IN(err),
    .CLAW_LEVEL_OUT(lvl), .CLAW_DOWN_OUT(down), .CLAW_UP_OUT(up), .GAME_ACTIVE_OUT(act),
    .CENTER_GANTRY_OUT(ctr), .DISPLAY_OUT(disp), .ALARM_OUT(alarm), .ATTRACT_OUT(attr),
    .PRIZE_SENSOR_LED_OUT(led), .COIN_METER_OUT(cm), .BILL_METER_OUT(bm), .PRIZE_METER_OUT(pm),
    .CREDITS_OUT(cred), .WIN_RATE_OUT(rate));
  ccg_far_side ccg_far_side_inst (.clk_in(clk), .claw_down_in(down), .claw_up_in(up), .claw_level_in(lvl),
    .bottom_hit_out(hit), .near_top_out(near), .top_limit_out(top), .home_out(home));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    if (lvl !== lv_old) lvq.push_back(lvl);
    lv_old = lvl;
    if (cm && !cm_old) n_coin++;
    if (bm && !bm_old) n_bill++;
    if (pm && !pm_old) n_prize++;
    if (ctr) n_ctr++;
    if (hit) n_hit++;
    cm_old = cm;
    bm_old = bm;
    pm_old = pm;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic boot(input logic [7:0] w, input logic [7:0] g, input logic [7:0] c, input logic [7:0] t);
    @(posedge clk);
    win <= w;
    gopt <= g;
    copt <= c;
    topt <= t;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  // input 0 coin, 1 dollar, 2 prize, 3 catch; low gap lets each edge be seen
  task automatic pulse(input int which, input int k);
    repeat (k) begin
      @(posedge clk);
      ev[which] <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic play(input logic [1:0] last, input int presses);
    int n;
    lvq.delete();
    pulse(3, presses);
    tick(1);
    chk(act, 1'b1);
    for (n = 0; n < 300 && lvq.size() < 4; n++) @(negedge clk);
    repeat (4) lvq.push_back(2'bxx);
    chk({lvq[0], lvq[1], lvq[2], lvq[3]}, {2'h1, 2'h2, last, 2'h0});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("wrong value at %0t: run hung", $time);
    give_verdict();
  end
  initial begin
    boot(8'hFF, 8'h0D, 8'h00, 8'h01);
    tick(5);
    chk(disp, 8'h00);
    chk(rate, 16'h04BA);
    tick(10);
    chk(disp, 8'h12);
    tick(10);
    chk(disp, 8'h00);
    tick(10);
    chk(disp, 8'h99);
    tick(10);
    chk(disp, 8'h88);
    tick(100);
    chk(cred, 16'h0000);
    chk(attr, 1'b1);
    pulse(3, 1);
    tick(5);
    chk(down, 1'b0);
    chk(act, 1'b0);
    pulse(0, 2);
    pulse(1, 1);
    tick(60);
    chk(n_coin, 2);
    chk(n_bill, 4);
    chk(disp, 8'h02);
    @(posedge clk) err <= 1'b1;
    tick(3);
    chk(alarm, 1'b1);
    @(posedge clk) err <= 1'b0;
    play(2'h3, 1);
    chk(cred, 16'h0001);
    @(posedge clk) pay <= 1'b1;
    play(2'h1, 1);
    @(posedge clk) pay <= 1'b0;
    chk(n_ctr, 2);
    $display("test 1 finished");
    pulse(0, 1);
    boot(8'h10, 8'h02, 8'h04, 8'h80);
    tick(5);
    chk(cred, 16'h0001);
    chk(rate, 16'h000A);
    tick(140);
    pulse(0, 7);
    tick(60);
    chk(disp, 8'h02);
    @(posedge clk) err <= 1'b1;
    tick(3);
    chk(alarm, 1'b0);
    @(posedge clk) err <= 1'b0;
    play(2'h3, 1);
    chk(cred, 16'h0004);
    play(2'h3, 1);
    chk(cred, 16'h0004);
    pulse(2, 1);
    tick(10);
    chk(n_prize, 1);
    play(2'h3, 1);
    chk(cred, 16'h0000);
    chk(n_ctr, 2);
    $display("test 2 finished");
    for (int i = 0; i < 3; i++) begin
      boot(8'h00, 8'h00, 8'h00, 8'h60 | (8'h10 >> i));
      tick(150);
      chk(lvl, 2'h1 + i[1:0]);
      chk(disp, 8'h11);
      chk(attr, 1'b0);
      chk(led, 1'b0);
      @(posedge clk) ev[2] <= 1'b1;
      tick(3);
      chk(led, 1'b1);
      @(posedge clk) ev[2] <= 1'b0;
    end
    $display("test 3 finished");
    boot(8'h00, 8'h80, 8'h00, 8'h00);
    tick(150);
    chk(attr, 1'b1);
    play(2'h3, 2);
    chk(n_hit, 5);
    chk(cred, 16'h0000);
    $display("test 4 finished");
    give_verdict();
  end
endmodule
